//--- core/bcg_pkg.sv
`default_nettype none
package bcg_pkg;
	// Register indices as printed; the byte address is four times the index
	localparam logic [7:0]  IDX_APBA_SEL     = 8'h09;
	localparam logic [7:0]  IDX_APBB_SEL     = 8'h0A;
	localparam logic [7:0]  IDX_APBC_SEL     = 8'h0B;
	localparam logic [7:0]  IDX_SYS_GATES    = 8'h14;
	localparam logic [7:0]  IDX_APBA_GATES   = 8'h18;
	localparam int          ADDR_W           = 10;
	localparam logic [9:0]  ADDR_APBA_SEL    = {IDX_APBA_SEL, 2'b00};
	localparam logic [9:0]  ADDR_APBB_SEL    = {IDX_APBB_SEL, 2'b00};
	localparam logic [9:0]  ADDR_APBC_SEL    = {IDX_APBC_SEL, 2'b00};
	localparam logic [9:0]  ADDR_SYS_GATES   = {IDX_SYS_GATES, 2'b00};
	localparam logic [9:0]  ADDR_APBA_GATES  = {IDX_APBA_GATES, 2'b00};
	localparam int          DIV_CODE_W       = 3;
	localparam int          DIV_CNT_W        = 7;
	localparam int          SYS_GATE_W       = 5;
	localparam int          APBA_GATE_W      = 7;
	localparam logic [2:0]  SEL_RESET        = 3'h0;
	localparam logic [4:0]  SYS_GATES_RESET  = 5'h1F;
	localparam logic [6:0]  APBA_GATES_RESET = 7'h7F;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef struct packed {
		logic flash_controller_gate;
		logic debug_unit_gate;
		logic periph_bridge2_gate;
		logic periph_bridge1_gate;
		logic periph_bridge0_gate;
	} bcg_sys_gates_type;

	typedef struct packed {
		logic external_interrupt_gate;
		logic rtc_gate;
		logic watchdog_gate;
		logic generic_clock_unit_gate;
		logic system_control_gate;
		logic power_manager_gate;
		logic access_protector0_gate;
	} bcg_apba_gates_type;

	typedef struct packed {
		logic tick_a;
		logic tick_b;
		logic tick_c;
	} bcg_ticks_type;
endpackage : bcg_pkg
`default_nettype wire

//--- core/bcg_top.sv
// Behaviour
// - First bus clock divided by two power code
// - Second bus clock divided by two power code
// - Third bus clock divided by two power code
// - Flash and debug system clocks follow bits
// - Bridge system clocks follow mask bits 2:0
// - Interrupt controller clock follows mask bit 6
// - Real-time counter clock follows mask bit 5
// - Five system peripherals follow mask bits 4:0
// - Writes ignored while access protector locks
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
module bcg_top (
	input  wire logic                        ref_clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        write_lock_in,
	input  wire logic [bcg_pkg::ADDR_W-1:0]  s_axi_awaddr_in,
	input  wire logic                        s_axi_awvalid_in,
	output logic                             s_axi_awready_out,
	input  wire logic [31:0]                 s_axi_wdata_in,
	input  wire logic [3:0]                  s_axi_wstrb_in,
	input  wire logic                        s_axi_wvalid_in,
	output logic                             s_axi_wready_out,
	output logic [1:0]                       s_axi_bresp_out,
	output logic                             s_axi_bvalid_out,
	input  wire logic                        s_axi_bready_in,
	input  wire logic [bcg_pkg::ADDR_W-1:0]  s_axi_araddr_in,
	input  wire logic                        s_axi_arvalid_in,
	output logic                             s_axi_arready_out,
	output logic [31:0]                      s_axi_rdata_out,
	output logic [1:0]                       s_axi_rresp_out,
	output logic                             s_axi_rvalid_out,
	input  wire logic                        s_axi_rready_in,
	output bcg_pkg::bcg_ticks_type           bus_ticks_out,
	output bcg_pkg::bcg_sys_gates_type       sys_gates_out,
	output bcg_pkg::bcg_apba_gates_type      apba_gates_out
);
	logic [1:0]                       rst_sync;
	logic                             rst_n;
	logic [bcg_pkg::DIV_CODE_W-1:0]   first_bus_div_code;
	logic [bcg_pkg::DIV_CODE_W-1:0]   second_bus_div_code;
	logic [bcg_pkg::DIV_CODE_W-1:0]   third_bus_div_code;
	logic [bcg_pkg::SYS_GATE_W-1:0]   sys_mask;
	logic [bcg_pkg::APBA_GATE_W-1:0]  apba_mask;
	logic [bcg_pkg::DIV_CNT_W-1:0]    div_cnt;
	logic [bcg_pkg::ADDR_W-1:0]       wr_addr;
	logic [31:0]                      wr_data;
	logic [3:0]                       wr_strb;
	logic [bcg_pkg::ADDR_W-1:0]       rd_addr;
	logic                             wr_fire;
	logic                             wr_hit;
	logic                             rd_hit;
	logic [31:0]                      rd_word;
	logic                             next_tick_a;
	logic                             next_tick_b;
	logic                             next_tick_c;

	// Reset is released through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Divider ticks: a code of n fires once every 2**n cycles
	function automatic logic tick_due(input logic [6:0] cnt, input logic [2:0] code);
		logic [6:0] sel_bits;
		sel_bits = 7'((8'h01 << code) - 8'h01);
		return (cnt & sel_bits) == sel_bits;
	endfunction : tick_due

	// One shared counter keeps the three bus rates phase aligned
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= div_cnt + 7'h01;
		end
	end

	always_comb begin
		next_tick_a = tick_due(div_cnt, first_bus_div_code);
		next_tick_b = tick_due(div_cnt, second_bus_div_code);
		next_tick_c = tick_due(div_cnt, third_bus_div_code);
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_ticks_out  <= '0;
			sys_gates_out  <= bcg_pkg::bcg_sys_gates_type'(bcg_pkg::SYS_GATES_RESET);
			apba_gates_out <= '0;
		end else begin
			bus_ticks_out  <= {next_tick_a, next_tick_b, next_tick_c};
			sys_gates_out  <= bcg_pkg::bcg_sys_gates_type'(sys_mask);
			// Peripheral enables pulse only on first-bus ticks, and only if unmasked
			apba_gates_out <= bcg_pkg::bcg_apba_gates_type'(apba_mask & {7{next_tick_a}});
		end
	end

	// Write channel: address and data are taken in either order
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready_out <= 1'b1;
			wr_addr           <= '0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			s_axi_awready_out <= 1'b0;
			wr_addr           <= s_axi_awaddr_in;
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_awready_out <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_wready_out <= 1'b1;
			wr_data          <= '0;
			wr_strb          <= '0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			s_axi_wready_out <= 1'b0;
			wr_data          <= s_axi_wdata_in;
			wr_strb          <= s_axi_wstrb_in;
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_wready_out <= 1'b1;
		end
	end

	always_comb begin
		wr_fire = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
		wr_hit  = wr_addr == bcg_pkg::ADDR_APBA_SEL || wr_addr == bcg_pkg::ADDR_APBB_SEL ||
			wr_addr == bcg_pkg::ADDR_APBC_SEL || wr_addr == bcg_pkg::ADDR_SYS_GATES ||
			wr_addr == bcg_pkg::ADDR_APBA_GATES;
	end

	// A locked or unmapped write is answered with an error and changes nothing
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= bcg_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= (wr_hit && !write_lock_in) ? bcg_pkg::RESP_OKAY : bcg_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Only byte lane 0 carries defined bits; upper bits are dropped
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			first_bus_div_code  <= bcg_pkg::SEL_RESET;
			second_bus_div_code <= bcg_pkg::SEL_RESET;
			third_bus_div_code  <= bcg_pkg::SEL_RESET;
			sys_mask            <= bcg_pkg::SYS_GATES_RESET;
			apba_mask           <= bcg_pkg::APBA_GATES_RESET;
		end else if (wr_fire && !write_lock_in && wr_strb[0]) begin
			unique case (wr_addr)
				bcg_pkg::ADDR_APBA_SEL:   first_bus_div_code  <= wr_data[2:0];
				bcg_pkg::ADDR_APBB_SEL:   second_bus_div_code <= wr_data[2:0];
				bcg_pkg::ADDR_APBC_SEL:   third_bus_div_code  <= wr_data[2:0];
				bcg_pkg::ADDR_SYS_GATES:  sys_mask            <= wr_data[4:0];
				bcg_pkg::ADDR_APBA_GATES: apba_mask           <= wr_data[6:0];
				default: begin
				end
			endcase
		end
	end

	// Read channel
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (rd_addr)
			bcg_pkg::ADDR_APBA_SEL:   rd_word = {29'h0, first_bus_div_code};
			bcg_pkg::ADDR_APBB_SEL:   rd_word = {29'h0, second_bus_div_code};
			bcg_pkg::ADDR_APBC_SEL:   rd_word = {29'h0, third_bus_div_code};
			bcg_pkg::ADDR_SYS_GATES:  rd_word = {27'h0, sys_mask};
			bcg_pkg::ADDR_APBA_GATES: rd_word = {25'h0, apba_mask};
			default:                  rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready_out <= 1'b1;
			rd_addr           <= '0;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			rd_addr           <= s_axi_araddr_in;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_arready_out <= 1'b1;
		end
	end

	// Data are sampled one cycle after the address is taken
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h0000_0000;
			s_axi_rresp_out  <= bcg_pkg::RESP_OKAY;
		end else if (!s_axi_arready_out && !s_axi_rvalid_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out  <= rd_word;
			s_axi_rresp_out  <= rd_hit ? bcg_pkg::RESP_OKAY : bcg_pkg::RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// Checks
	// The code must stand a cycle before the tick: a tick launched under the old code says nothing
	sequence s_sel_a_one_hold;
		first_bus_div_code == 3'h1 ##1 bus_ticks_out.tick_a && first_bus_div_code == 3'h1
			##1 first_bus_div_code == 3'h1;
	endsequence

	property p_div_a_by_two;
		@(posedge ref_clk_in) disable iff (!rst_n)
		s_sel_a_one_hold |-> !bus_ticks_out.tick_a ##1 bus_ticks_out.tick_a;
	endproperty
	a_div_a_by_two: assert property (p_div_a_by_two) else $error("first bus divide by two broken");

	property p_div_b_by_one;
		@(posedge ref_clk_in) disable iff (!rst_n)
		second_bus_div_code == 3'h0 |=> bus_ticks_out.tick_b;
	endproperty
	a_div_b_by_one: assert property (p_div_b_by_one) else $error("second bus divide by one broken");

	sequence s_sel_c_max_hold;
		third_bus_div_code == 3'h7 ##1 bus_ticks_out.tick_c && third_bus_div_code == 3'h7
			##1 (third_bus_div_code == 3'h7)[*8];
	endsequence

	property p_div_c_max;
		@(posedge ref_clk_in) disable iff (!rst_n)
		s_sel_c_max_hold |-> !bus_ticks_out.tick_c;
	endproperty
	a_div_c_max: assert property (p_div_c_max) else $error("third bus tick came too early");

	property p_flash_stop;
		@(posedge ref_clk_in) disable iff (!rst_n)
		wr_fire && !write_lock_in && wr_strb[0] && wr_addr == bcg_pkg::ADDR_SYS_GATES && !wr_data[4]
		|=> ##1 !sys_gates_out.flash_controller_gate;
	endproperty
	a_flash_stop: assert property (p_flash_stop) else $error("flash clock not stopped");

	property p_bridges_run;
		@(posedge ref_clk_in) disable iff (!rst_n)
		wr_fire && !write_lock_in && wr_strb[0] && wr_addr == bcg_pkg::ADDR_SYS_GATES && wr_data[2:0] == 3'h7
		|=> ##1 sys_gates_out.periph_bridge2_gate && sys_gates_out.periph_bridge1_gate &&
			sys_gates_out.periph_bridge0_gate;
	endproperty
	a_bridges_run: assert property (p_bridges_run) else $error("bridge clocks not running");

	property p_debug_stop;
		@(posedge ref_clk_in) disable iff (!rst_n)
		wr_fire && !write_lock_in && wr_strb[0] && wr_addr == bcg_pkg::ADDR_SYS_GATES && !wr_data[3]
		|=> ##1 !sys_gates_out.debug_unit_gate;
	endproperty
	a_debug_stop: assert property (p_debug_stop) else $error("debug unit clock not stopped");

	property p_bridge1_stop;
		@(posedge ref_clk_in) disable iff (!rst_n)
		wr_fire && !write_lock_in && wr_strb[0] && wr_addr == bcg_pkg::ADDR_SYS_GATES && !wr_data[1]
		|=> ##1 !sys_gates_out.periph_bridge1_gate;
	endproperty
	a_bridge1_stop: assert property (p_bridge1_stop) else $error("bridge 1 clock not stopped");

	property p_irq_ctrl_gate;
		@(posedge ref_clk_in) disable iff (!rst_n)
		apba_gates_out.external_interrupt_gate |-> bus_ticks_out.tick_a && $past(apba_mask[6]);
	endproperty
	a_irq_ctrl_gate: assert property (p_irq_ctrl_gate) else $error("interrupt controller enable without cause");

	property p_rtc_gate;
		@(posedge ref_clk_in) disable iff (!rst_n)
		apba_mask[5] && next_tick_a |=> apba_gates_out.rtc_gate;
	endproperty
	a_rtc_gate: assert property (p_rtc_gate) else $error("real-time counter enable missing");

	property p_rtc_stop;
		@(posedge ref_clk_in) disable iff (!rst_n)
		!apba_mask[5] |=> !apba_gates_out.rtc_gate;
	endproperty
	a_rtc_stop: assert property (p_rtc_stop) else $error("real-time counter enable while masked");

	property p_sys_periph_gates;
		@(posedge ref_clk_in) disable iff (!rst_n)
		next_tick_a |=> apba_gates_out[4:0] == $past(apba_mask[4:0]);
	endproperty
	a_sys_periph_gates: assert property (p_sys_periph_gates) else $error("peripheral enables wrong");

	property p_lock_holds;
		@(posedge ref_clk_in) disable iff (!rst_n)
		wr_fire && write_lock_in |=> $stable(sys_mask) && $stable(apba_mask) &&
			$stable(first_bus_div_code) && $stable(second_bus_div_code) && $stable(third_bus_div_code) &&
			s_axi_bresp_out == bcg_pkg::RESP_SLVERR;
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked write changed state");

	property p_unused_zero;
		@(posedge ref_clk_in) disable iff (!rst_n)
		s_axi_rvalid_out && s_axi_rresp_out == bcg_pkg::RESP_OKAY |-> s_axi_rdata_out[31:7] == 25'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");
endmodule : bcg_top
`default_nettype wire

//--- test/bcg_clock_sink.sv
`default_nettype none
module bcg_clock_sink (
	input  wire logic                        ref_clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        clear_in,
	input  wire bcg_pkg::bcg_ticks_type      ticks_in,
	input  wire bcg_pkg::bcg_apba_gates_type apba_gates_in,
	output logic [15:0]                      tick_cnt_out [3],
	output logic [15:0]                      gate_cnt_out [7]
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] tick_bits;
	logic [6:0] gate_bits;
	assign tick_bits = {ticks_in.tick_c, ticks_in.tick_b, ticks_in.tick_a};
	assign gate_bits = apba_gates_in;
	// Raw enables are counted, so a gate that fires off the bus tick shows up as a wrong count
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt_out <= '{default: '0};
			gate_cnt_out <= '{default: '0};
		end else if (clear_in) begin
			tick_cnt_out <= '{default: '0};
			gate_cnt_out <= '{default: '0};
		end else begin
			for (int i = 0; i < 3; i++) begin
				tick_cnt_out[i] <= tick_cnt_out[i] + 16'(tick_bits[i]);
			end
			for (int i = 0; i < 7; i++) begin
				gate_cnt_out[i] <= gate_cnt_out[i] + 16'(gate_bits[i]);
			end
		end
	end
endmodule : bcg_clock_sink
`default_nettype wire

//--- test/test_bus_clock_prescale_and_gating.sv
`default_nettype none
module test_bus_clock_prescale_and_gating;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        lock = 1'b0;
	logic        clear = 1'b0;
	logic [9:0]  awaddr = '0;
	logic [9:0]  araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, data;
	bcg_pkg::bcg_ticks_type      ticks;
	bcg_pkg::bcg_sys_gates_type  sys_gates;
	bcg_pkg::bcg_apba_gates_type apba_gates;
	logic [15:0] tick_cnt [3];
	logic [15:0] gate_cnt [7];
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;

	bcg_top dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .write_lock_in(lock),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.bus_ticks_out(ticks), .sys_gates_out(sys_gates), .apba_gates_out(apba_gates));
	bcg_clock_sink sink_u (.ref_clk_in(clk), .rst_n_in(rst_n), .clear_in(clear), .ticks_in(ticks),
		.apba_gates_in(apba_gates), .tick_cnt_out(tick_cnt), .gate_cnt_out(gate_cnt));

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic fail(input string m);
		miscompares++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask : fail

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) fail(m);
	endtask : check

	// Word writes with only lane 0 enabled stand in for byte access to the select registers
	task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
		bit aw_hs, w_hs, b_hs;
		int n;
		b_hs = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hs && n < 64) begin
			@(negedge clk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid && bready;
			resp = bresp;
			@(posedge clk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (b_hs) bready <= 1'b0;
			n++;
		end
		if (!b_hs) fail("write never answered");
	endtask : axi_write

	task automatic axi_read(input logic [9:0] a);
		bit ar_hs, r_hs;
		int n;
		r_hs = 1'b0;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hs && n < 64) begin
			@(negedge clk);
			ar_hs = arvalid && arready;
			r_hs = rvalid && rready;
			resp = rresp;
			data = rdata;
			@(posedge clk);
			if (ar_hs) arvalid <= 1'b0;
			if (r_hs) rready <= 1'b0;
			n++;
		end
		if (!r_hs) fail("read never answered");
	endtask : axi_read

	// Exactly 256 counted edges, a whole multiple of every divide ratio
	task automatic measure();
		@(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (256) @(posedge clk);
		@(negedge clk);
	endtask : measure

	task automatic test_reset();
		logic [9:0]  a [5];
		logic [31:0] v [5];
		a = '{bcg_pkg::ADDR_APBA_SEL, bcg_pkg::ADDR_APBB_SEL, bcg_pkg::ADDR_APBC_SEL,
			bcg_pkg::ADDR_SYS_GATES, bcg_pkg::ADDR_APBA_GATES};
		v = '{32'h0, 32'h0, 32'h0, 32'h1F, 32'h7F};
		for (int i = 0; i < 5; i++) begin
			axi_read(a[i]);
			check(data, v[i], "reset value");
			check(32'(resp), 32'(bcg_pkg::RESP_OKAY), "mapped read response");
		end
		check(32'(sys_gates), 32'h1F, "system gates after reset");
		$display("test_reset done");
	endtask : test_reset

	task automatic test_dividers();
		logic [9:0] a [3];
		a = '{bcg_pkg::ADDR_APBA_SEL, bcg_pkg::ADDR_APBB_SEL, bcg_pkg::ADDR_APBC_SEL};
		for (int b = 0; b < 3; b++) begin
			for (int c = 0; c < 8; c++) begin
				axi_write(a[b], 32'hFFFFFFF8 | 32'(c), 4'h1);
				check(32'(resp), 32'(bcg_pkg::RESP_OKAY), "select write response");
				axi_read(a[b]);
				check(data, 32'(c), "select readback");
				measure();
				check(32'(tick_cnt[b]), 32'(256 >> c), "bus tick count");
			end
		end
		$display("test_dividers done");
	endtask : test_dividers

	task automatic test_sys_gates();
		logic [4:0] p [3];
		p = '{5'h15, 5'h0A, 5'h1F};
		for (int i = 0; i < 3; i++) begin
			axi_write(bcg_pkg::ADDR_SYS_GATES, 32'hFFFFFFE0 | 32'(p[i]), 4'h1);
			repeat (2) @(posedge clk);
			@(negedge clk);
			check(32'(sys_gates), 32'(p[i]), "system gate levels");
			axi_read(bcg_pkg::ADDR_SYS_GATES);
			check(data, 32'(p[i]), "system mask readback");
		end
		$display("test_sys_gates done");
	endtask : test_sys_gates

	task automatic test_apba_gates();
		axi_write(bcg_pkg::ADDR_APBA_SEL, 32'h1, 4'h1);
		axi_write(bcg_pkg::ADDR_APBA_GATES, 32'hFFFFFF55, 4'h1);
		axi_read(bcg_pkg::ADDR_APBA_GATES);
		check(data, 32'h55, "bus A mask readback");
		measure();
		for (int i = 0; i < 7; i++) begin
			check(32'(gate_cnt[i]), ((32'h55 >> i) & 1) != 0 ? 32'd128 : 32'd0, "bus A gate count");
		end
		$display("test_apba_gates done");
	endtask : test_apba_gates

	task automatic test_refusals();
		@(posedge clk);
		lock <= 1'b1;
		axi_write(bcg_pkg::ADDR_SYS_GATES, 32'h0, 4'h1);
		check(32'(resp), 32'(bcg_pkg::RESP_SLVERR), "locked write response");
		axi_write(bcg_pkg::ADDR_APBA_SEL, 32'h5, 4'h1);
		lock <= 1'b0;
		check(32'(resp), 32'(bcg_pkg::RESP_SLVERR), "locked select write response");
		axi_write(bcg_pkg::ADDR_SYS_GATES, 32'h0, 4'h0);
		check(32'(resp), 32'(bcg_pkg::RESP_OKAY), "empty strobe response");
		axi_read(bcg_pkg::ADDR_SYS_GATES);
		check(data, 32'h1F, "mask kept after refused writes");
		check(32'(sys_gates), 32'h1F, "gates kept after refused writes");
		axi_read(bcg_pkg::ADDR_APBA_SEL);
		check(data, 32'h1, "select kept after locked write");
		axi_write(10'h030, 32'h0, 4'h1);
		check(32'(resp), 32'(bcg_pkg::RESP_SLVERR), "unmapped write response");
		axi_read(10'h030);
		check(32'(resp), 32'(bcg_pkg::RESP_SLVERR), "unmapped read response");
		check(data, 32'h0, "unmapped read data");
		$display("test_refusals done");
	endtask : test_refusals

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail("run took too long");
			give_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		test_reset();
		test_dividers();
		test_sys_gates();
		test_apba_gates();
		test_refusals();
		give_verdict();
	end
endmodule : test_bus_clock_prescale_and_gating
`default_nettype wire
